// ---- logic/socket_consts.svh ----
// Constants for the socket mask and present-state register bank
// Operation
// - Mask selects events raising status change interrupt
// - Masked events still set their event flags
// - Unused mask and state bits read zero
// - Bit 3 enables power change interrupt
// - Detect mask 11 enables, 00 blocks, reset 00
// - Bit 0 enables card status interrupt
// - Bus reset only when PME disabled, global reset always
// - State shows live socket and forced values
// - Voltage caps and type captured at insertion
// - Detect changes during identification stay hidden
// - Future voltage socket bits read zero
// - Low voltage socket bit reads one
// - High voltage socket bit one unless overridden
// - Card voltage bits settable by force writes
// - Bad supply flag shows invalid power request
// - State read-only, resets 3000 00XX
// - Card status edge rules, write one clears
// - Detect, power, status bits follow pins
`ifndef SOCKET_CONSTS_SVH
`define SOCKET_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SOCK_ADDR_W 8
`define SOCK_EVENT_OFS 8'h00
`define SOCK_MASK_OFS 8'h04
`define SOCK_STATE_OFS 8'h08
`define SOCK_FORCE_OFS 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EV_STATUS_BIT 0
`define EV_DET1_BIT 1
`define EV_DET2_BIT 2
`define EV_POWER_BIT 3
`define MASK_DET_LO 1
`define MASK_DET_HI 2
`define ST_FUTURE_V2_BIT 31
`define ST_FUTURE_V1_BIT 30
`define ST_LOW_V_BIT 29
`define ST_HIGH_V_BIT 28
`define ST_CARD_V_HI 13
`define ST_CARD_V_LO 10
`define ST_BAD_REQ_BIT 9
`define FORCE_BAD_REQ_BIT 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MASK_RESET 4'h0
`define EVENT_RESET 4'h0
`define CARD_V_RESET 4'h0
`define DETECT_RESET 2'h3
`define DETECT_ENABLED 2'h3
`define SOCKET_FUTURE_V 1'h0
`define SOCKET_LOW_V 1'h1
`define SOCKET_HIGH_V 1'h1

`endif

// ---- logic/socket_pkg.sv ----
// Types shared by the socket register bank
package socket_pkg;

  // Live socket pins sampled each clock
  typedef struct packed {
    logic detect_two;
    logic detect_one;
    logic card_status;
    logic powered;
  } socket_pins_type;

  // Register access request from the host side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage

// ---- logic/socket_event_flags.sv ----
// Sticky socket event flags with edge detection
`timescale 1ns/10ps
`include "socket_consts.svh"
module socket_event_flags (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_clear_i,
  input wire logic [3:0] state_i,
  input wire logic cardbus_i,
  input wire logic [3:0] clear_i,
  input wire logic [3:0] force_i,
  output logic [3:0] flags_o
);

  logic [3:0] prev;
  logic primed;
  logic [3:0] change;
  logic [3:0] next_flags;

  // -------------------------------------------------------------
  // Change detection
  // -------------------------------------------------------------
  // Status pin: rising only for CardBus, both edges for 16-bit
  assign change[`EV_STATUS_BIT] = primed &&
    (cardbus_i ? (state_i[`EV_STATUS_BIT] && !prev[`EV_STATUS_BIT])
               : (state_i[`EV_STATUS_BIT] != prev[`EV_STATUS_BIT]));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
      if (gi != `EV_STATUS_BIT) begin : g_any
        // Either direction counts for detect and power
        assign change[gi] = primed && (state_i[gi] != prev[gi]);
      end
      // Set beats clear so an event in the clear cycle is kept
      assign next_flags[gi] = change[gi] || force_i[gi] ||
                              (flags_o[gi] && !clear_i[gi]);
    end
  endgenerate

  // -------------------------------------------------------------
  // Flag and history registers
  // -------------------------------------------------------------
  // First cycle after reset only primes history, no false event
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o <= `EVENT_RESET;
      prev <= 4'h0;
      primed <= 1'b0;
    end else if (soft_clear_i) begin
      flags_o <= `EVENT_RESET;
      prev <= state_i;
      primed <= 1'b1;
    end else begin
      flags_o <= next_flags;
      prev <= state_i;
      primed <= 1'b1;
    end
  end

endmodule

// ---- logic/card_capture.sv ----
// Card voltage capability and type captured at insertion
`timescale 1ns/10ps
`include "socket_consts.svh"
module card_capture (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic soft_clear_i,
  input wire logic identify_done_i,
  input wire logic [3:0] card_v_caps_i,
  input wire logic card_is_cardbus_i,
  input wire logic force_wr_i,
  input wire logic [3:0] force_v_i,
  output logic [3:0] card_v_o,
  output logic cardbus_o
);

  // -------------------------------------------------------------
  // Capture on insertion, force writes may only add bits
  // -------------------------------------------------------------
  // Held between insertions so a flaky pin cannot alter them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      card_v_o <= `CARD_V_RESET;
      cardbus_o <= 1'b0;
    end else if (soft_clear_i) begin
      card_v_o <= `CARD_V_RESET;
      cardbus_o <= 1'b0;
    end else if (identify_done_i) begin
      card_v_o <= card_v_caps_i;
      cardbus_o <= card_is_cardbus_i;
    end else if (force_wr_i) begin
      card_v_o <= card_v_o | force_v_i;
    end
  end

endmodule

// ---- logic/socket_mask_and_present_state.sv ----
// Socket event, mask, present-state and force-event registers
`timescale 1ns/10ps
`include "socket_consts.svh"
module socket_mask_and_present_state (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_reset_pin_i,
  input wire logic pme_enable_i,
  input wire socket_pkg::reg_req_type req_i,
  output logic [31:0] reg_rdata_o,
  input wire socket_pkg::socket_pins_type pins_i,
  input wire logic identify_busy_i,
  input wire logic identify_done_i,
  input wire logic [3:0] card_v_caps_i,
  input wire logic card_is_cardbus_i,
  input wire logic invalid_supply_request_i,
  input wire logic high_v_disable_i,
  output logic status_change_interrupt_o
);

  // -------------------------------------------------------------
  // Reset selection
  // -------------------------------------------------------------
  // Bus reset only clears context when PME is off
  logic soft_clear;
  assign soft_clear = bus_reset_pin_i && !pme_enable_i;

  // -------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------
  logic hit_event;
  logic hit_mask;
  logic hit_state;
  logic hit_force;
  logic wr_event;
  logic wr_mask;
  logic wr_force;
  assign hit_event = (req_i.addr == `SOCK_EVENT_OFS);
  assign hit_mask = (req_i.addr == `SOCK_MASK_OFS);
  assign hit_state = (req_i.addr == `SOCK_STATE_OFS);
  assign hit_force = (req_i.addr == `SOCK_FORCE_OFS);
  assign wr_event = req_i.wr && hit_event;
  assign wr_mask = req_i.wr && hit_mask;
  assign wr_force = req_i.wr && hit_force;
  // Present state has no write decode at all

  // -------------------------------------------------------------
  // Detect line hold during identification
  // -------------------------------------------------------------
  // Bridge drives the detect lines itself while identifying
  logic [1:0] detect_held;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      detect_held <= `DETECT_RESET;
    end else if (!identify_busy_i) begin
      detect_held <= {pins_i.detect_two, pins_i.detect_one};
    end
  end

  // -------------------------------------------------------------
  // Live low bits of present state
  // -------------------------------------------------------------
  logic [3:0] live_bits;
  assign live_bits[`EV_STATUS_BIT] = pins_i.card_status;
  assign live_bits[`EV_DET1_BIT] = detect_held[0];
  assign live_bits[`EV_DET2_BIT] = detect_held[1];
  assign live_bits[`EV_POWER_BIT] = pins_i.powered;

  // -------------------------------------------------------------
  // Card capability capture
  // -------------------------------------------------------------
  logic [3:0] card_v;
  logic cardbus;
  card_capture u_capture (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .soft_clear_i(soft_clear),
    .identify_done_i(identify_done_i),
    .card_v_caps_i(card_v_caps_i),
    .card_is_cardbus_i(card_is_cardbus_i),
    .force_wr_i(wr_force),
    .force_v_i(req_i.wdata[`ST_CARD_V_HI:`ST_CARD_V_LO]),
    .card_v_o(card_v),
    .cardbus_o(cardbus)
  );

  // -------------------------------------------------------------
  // Event flags
  // -------------------------------------------------------------
  logic [3:0] event_flags;
  logic [3:0] event_clear;
  logic [3:0] event_force;
  assign event_clear = wr_event ? req_i.wdata[3:0] : 4'h0;
  assign event_force = wr_force ? req_i.wdata[3:0] : 4'h0;

  socket_event_flags u_events (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .soft_clear_i(soft_clear),
    .state_i(live_bits),
    .cardbus_i(cardbus),
    .clear_i(event_clear),
    .force_i(event_force),
    .flags_o(event_flags)
  );

  // -------------------------------------------------------------
  // Mask register
  // -------------------------------------------------------------
  logic [3:0] mask;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= `MASK_RESET;
    end else if (soft_clear) begin
      mask <= `MASK_RESET;
    end else if (wr_mask) begin
      mask <= req_i.wdata[3:0];
    end
  end

  // -------------------------------------------------------------
  // Forced bad supply request
  // -------------------------------------------------------------
  // Force write sets or clears it; the live request is ORed in
  logic bad_req_forced;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bad_req_forced <= 1'b0;
    end else if (soft_clear) begin
      bad_req_forced <= 1'b0;
    end else if (wr_force) begin
      bad_req_forced <= req_i.wdata[`FORCE_BAD_REQ_BIT];
    end
  end

  // -------------------------------------------------------------
  // Interrupt gating
  // -------------------------------------------------------------
  // Reserved detect mask codes 01 and 10 are treated as blocking
  logic detect_en;
  logic [3:0] enable_bits;
  logic next_irq;
  assign detect_en = (mask[`MASK_DET_HI:`MASK_DET_LO] == `DETECT_ENABLED);
  assign enable_bits[`EV_STATUS_BIT] = mask[`EV_STATUS_BIT];
  assign enable_bits[`EV_DET1_BIT] = detect_en;
  assign enable_bits[`EV_DET2_BIT] = detect_en;
  assign enable_bits[`EV_POWER_BIT] = mask[`EV_POWER_BIT];
  assign next_irq = |(event_flags & enable_bits);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_change_interrupt_o <= 1'b0;
    end else begin
      status_change_interrupt_o <= next_irq;
    end
  end

  // -------------------------------------------------------------
  // Read data
  // -------------------------------------------------------------
  logic [31:0] state_word;
  logic [31:0] mask_word;
  logic [31:0] event_word;
  logic [31:0] next_rdata;
  assign mask_word = {28'h0000000, mask};
  assign event_word = {28'h0000000, event_flags};
  always_comb begin
    state_word = 32'h00000000;
    state_word[`ST_FUTURE_V2_BIT] = `SOCKET_FUTURE_V;
    state_word[`ST_FUTURE_V1_BIT] = `SOCKET_FUTURE_V;
    state_word[`ST_LOW_V_BIT] = `SOCKET_LOW_V;
    state_word[`ST_HIGH_V_BIT] = `SOCKET_HIGH_V && !high_v_disable_i;
    state_word[`ST_CARD_V_HI:`ST_CARD_V_LO] = card_v;
    state_word[`ST_BAD_REQ_BIT] = invalid_supply_request_i || bad_req_forced;
    state_word[3:0] = live_bits;
  end

  // Force register and unmapped offsets read as zero
  assign next_rdata = hit_event ? event_word :
                      hit_mask ? mask_word :
                      hit_state ? state_word : 32'h00000000;

  // Registered so the read port is glitch free
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (req_i.rd) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule

// ---- bench/socket_bank_sva.sv ----
// Port-level concurrent checks for the socket register bank
`timescale 1ns/10ps
module socket_bank_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire socket_pkg::reg_req_type req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire socket_pkg::socket_pins_type pins_i,
  input wire logic identify_busy_i,
  input wire logic invalid_supply_request_i,
  input wire logic high_v_disable_i,
  input wire logic status_change_interrupt_o
);
  // Request decodes, by offset
  wire logic rd_mk = req_i.rd && req_i.addr == 8'h04;
  wire logic rd_st = req_i.rd && req_i.addr == 8'h08;
  wire logic wr_mk = req_i.wr && req_i.addr == 8'h04;
  wire logic mapped = req_i.addr inside {8'h00, 8'h04, 8'h08, 8'h0C};
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ------------------------------
  // Read data and interrupt checks
  // ------------------------------
  property p_mask_zero;
    rd_mk |=> reg_rdata_o[31:4] == 28'h0;
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("mask upper bits not zero");
  property p_state_const;
    rd_st |=> reg_rdata_o[31:29] == 3'h1 && reg_rdata_o[27:14] == 14'h0;
  endproperty
  a_state_const: assert property (p_state_const)
    else $error("state constant bits wrong");
  property p_high_v;
    rd_st && $stable(high_v_disable_i)
      |=> reg_rdata_o[28] == !$past(high_v_disable_i);
  endproperty
  a_high_v: assert property (p_high_v)
    else $error("high voltage socket bit wrong");
  property p_bad_req;
    rd_st && invalid_supply_request_i |=> reg_rdata_o[9];
  endproperty
  a_bad_req: assert property (p_bad_req)
    else $error("bad supply flag missing");
  // Pins held two cycles so a sync stage has settled
  property p_pins;
    rd_st && $stable(pins_i) && $past(pins_i) == $past(pins_i, 2)
      && !identify_busy_i && !$past(identify_busy_i)
      |=> reg_rdata_o[3:0] == {$past(pins_i[0]), $past(pins_i[3:1])};
  endproperty
  a_pins: assert property (p_pins)
    else $error("live socket bits wrong");
  property p_unmapped;
    req_i.rd && !mapped |=> reg_rdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_mask_off;
    wr_mk && req_i.wdata[3:0] == 4'h0 |-> ##2 !status_change_interrupt_o;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt with all masks clear");
  property p_det_hold;
    rd_st && $past(rd_st) && identify_busy_i && $past(identify_busy_i)
      |=> reg_rdata_o[2:1] == $past(reg_rdata_o[2:1]);
  endproperty
  a_det_hold: assert property (p_det_hold)
    else $error("detect bits moved during identify");
endmodule
bind socket_mask_and_present_state socket_bank_sva u_sva (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .req_i(req_i),
  .reg_rdata_o(reg_rdata_o),
  .pins_i(pins_i),
  .identify_busy_i(identify_busy_i),
  .invalid_supply_request_i(invalid_supply_request_i),
  .high_v_disable_i(high_v_disable_i),
  .status_change_interrupt_o(status_change_interrupt_o)
);

// ---- bench/socket_card_model.sv ----
// Behavioural card in the socket with the identify sequence
`timescale 1ns/10ps
module socket_card_model (
  input wire logic sys_clk_i,
  input wire logic insert_i,
  input wire logic status_i,
  input wire logic powered_i,
  input wire logic cardbus_i,
  input wire logic [3:0] caps_i,
  output socket_pkg::socket_pins_type pins_o,
  output logic busy_o,
  output logic done_o,
  output logic cardbus_o,
  output logic [3:0] caps_o
);
  logic [2:0] cnt = 3'h0;
  logic present = 1'h0;
  // Insertion starts a short identify; done is its last cycle
  always @(posedge sys_clk_i) begin
    present <= insert_i;
    if (insert_i && !present) cnt <= 3'h5;
    else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
  // --------------
  // Pin levels
  // --------------
  assign busy_o = cnt > 3'h1;
  assign done_o = cnt == 3'h1;
  // Identify drives the detect lines, so they wobble while busy
  assign pins_o.detect_two = busy_o ? cnt[0] : !present;
  assign pins_o.detect_one = busy_o ? !cnt[0] : !present;
  assign pins_o.card_status = status_i;
  assign pins_o.powered = powered_i;
  // Caps and type only valid in the done cycle, junk otherwise
  assign caps_o = done_o ? caps_i : ~caps_i;
  assign cardbus_o = done_o ? cardbus_i : !cardbus_i;
endmodule

// ---- bench/socket_mask_and_present_state_tb_top.sv ----
// Self-checking bench for the socket mask and present-state bank
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module socket_mask_and_present_state_tb_top;
  logic clk, rst, bus_rst, pme, busy, done, cb, cbo, bad, fb, hvd;
  logic ins, sts, pwr, irq;
  logic [3:0] caps, capo, cv;
  logic [31:0] rdata, q;
  socket_pkg::reg_req_type req;
  socket_pkg::socket_pins_type pins;
  int bad_count = 0;
  int tests_run = 0;
  socket_mask_and_present_state dut (.sys_clk_i(clk), .rst_i(rst),
    .bus_reset_pin_i(bus_rst), .pme_enable_i(pme), .req_i(req),
    .reg_rdata_o(rdata), .pins_i(pins), .identify_busy_i(busy),
    .identify_done_i(done), .card_v_caps_i(capo),
    .card_is_cardbus_i(cbo), .invalid_supply_request_i(bad),
    .high_v_disable_i(hvd), .status_change_interrupt_o(irq));
  socket_card_model card (.sys_clk_i(clk), .insert_i(ins), .status_i(sts),
    .powered_i(pwr), .cardbus_i(cb), .caps_i(caps), .pins_o(pins),
    .busy_o(busy), .done_o(done), .cardbus_o(cbo), .caps_o(capo));
  // --------------------
  // Expectations and bus
  // --------------------
  function automatic logic [31:0] st(logic [1:0] d, logic [3:0] v);
    return {3'h1, !hvd, 14'h0, v, bad | fb, 5'h0, pwr, d, sts};
  endfunction
  // Detect events share one two-bit enable
  function automatic logic ie(int e, logic [3:0] m);
    return e == 0 ? m[0] : e == 3 ? m[3] : &m[2:1];
  endfunction
  // Request held n edges; a gap cycle follows so no double drive
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, int n);
    @(negedge clk);
    req = '{w, !w, a, d};
    repeat (n) @(negedge clk);
    q = rdata;
    req = '0;
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] e);
    acc(1'h0, a, 32'h0, 1);
    `CHK(q, e)
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    acc(1'h1, a, d, 1);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Watchdog far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
  // Main sequence
  initial begin
    {rst, bus_rst, pme, cb, bad, fb, hvd, ins, sts, pwr} = 10'h200;
    req = '0;
    caps = 4'h0;
    cv = 4'h0;
    void'($urandom(74));
    repeat (20) @(negedge clk);
    rst = 1'h0;
    repeat (3) @(negedge clk);
    rdc(8'h04, 32'h0);
    rdc(8'h08, st(2'h3, 4'h0));
    rdc(8'h10, 32'h0);
    wr(8'h08, 32'hFFFFFFFF);
    rdc(8'h08, st(2'h3, 4'h0));
    for (int m = 0; m < 16; m++) begin
      wr(8'h04, ($urandom << 4) | 32'(m));
      rdc(8'h04, 32'(m));
      for (int e = 0; e < 4; e++) begin
        wr(8'h00, 32'hF);
        wr(8'h0C, 32'h1 << e);
        rdc(8'h00, 32'h1 << e);
        `CHK(irq, ie(e, m[3:0]))
      end
    end
    wr(8'h04, 32'h0);
    // CardBus card first, then a 16-bit card
    for (int k = 0; k < 2; k++) begin
      cb = k == 0;
      caps = 4'($urandom);
      cv = caps;
      ins = 1'h1;
      repeat (2) @(negedge clk);
      acc(1'h0, 8'h08, 32'h0, 2);
      `CHK(q[2:1], 2'h3)
      repeat (6) @(negedge clk);
      caps = ~caps;
      rdc(8'h08, st(2'h0, cv));
      wr(8'h00, 32'hF);
      sts = 1'h1;
      repeat (3) @(negedge clk);
      rdc(8'h00, 32'h1);
      wr(8'h00, 32'hF);
      sts = 1'h0;
      repeat (3) @(negedge clk);
      rdc(8'h00, 32'(!cb));
      ins = 1'h0;
      repeat (3) @(negedge clk);
    end
    for (int i = 0; i < 8; i++) begin
      {pwr, hvd, bad, sts} = 4'($urandom);
      repeat (3) @(negedge clk);
      rdc(8'h08, st(2'h3, cv));
    end
    fb = 1'h1;
    wr(8'h0C, 32'h3E00);
    rdc(8'h08, st(2'h3, 4'hF));
    pme = 1'h1;
    wr(8'h04, 32'hF);
    bus_rst = 1'h1;
    @(negedge clk);
    bus_rst = 1'h0;
    rdc(8'h04, 32'hF);
    pme = 1'h0;
    bus_rst = 1'h1;
    @(negedge clk);
    bus_rst = 1'h0;
    fb = 1'h0;
    rdc(8'h04, 32'h0);
    rdc(8'h08, st(2'h3, 4'h0));
    give_verdict;
  end
endmodule
